// ===== logic/eodr_pkg.sv
/*
  Shared constants and types of the end-of-discharge detector.
  Assumes every user of it names items as eodr_pkg::name.
*/
package eodr_pkg;
  localparam int NCOL = 8;
  localparam int NROW = 8;
  localparam int TBL_AW = 6;
  // threshold decode: millivolts = base + step * code
  localparam logic [15:0] EOD_MV_BASE = 16'h0a8c;
  localparam logic [15:0] EOD_MV_STEP = 16'h0004;
  // residual codes: this value means 100 %
  localparam logic [15:0] RESIDUAL_FULL = 16'h00ff;
  localparam logic [15:0] RSOC_FULL = 16'h0064;
  localparam logic [7:0] MAX_ERROR_CAP = 8'h64;
  // temperature code = (celsius*10+200)/4, so degrees = codes*4/10
  localparam logic [11:0] TCODE_NUM = 12'h004;
  localparam logic [11:0] TCODE_DEN = 12'h00a;
  // status word bit positions
  localparam int BIT_DISCHARGE_END = 11;
  localparam int BIT_LOW_CHARGE = 9;
  localparam int BIT_LOW_RUNTIME = 8;
  localparam int BIT_FULLY_CHARGED = 5;
  // reset value and minimum confirmation count
  localparam logic [15:0] LFC_RESET = 16'h0fa0;
  localparam logic [7:0] CONFIRM_MIN = 8'h01;

  typedef enum logic [2:0] {
    ST_WATCH = 3'b001,
    ST_COUNT = 3'b010,
    ST_ENDED = 3'b100
  } eodr_state_t;
endpackage

// ===== logic/eodr_tbl_if.sv
/*
  Carrier between the detector and its threshold table memory.
  Assumes both ends run on the detector clock.
*/
`timescale 1ns/1ps
interface eodr_tbl_if;
  logic wr_en;
  logic [eodr_pkg::TBL_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [eodr_pkg::TBL_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

// ===== logic/eodr_tbl_mem.sv
/*
  64-entry byte table of end-of-discharge voltage codes.
  Assumes loading by the owner before use; read data is registered.
*/
`timescale 1ns/1ps
module eodr_tbl_mem (
  input wire logic mclk,
  input wire logic rst_n,
  eodr_tbl_if.mem tbl
);
  logic [7:0] mem [0:(1<<eodr_pkg::TBL_AW)-1];

  always_ff @(posedge mclk) begin
    if (tbl.wr_en) begin
      mem[tbl.wr_addr] <= tbl.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl.rd_data <= 8'h00;
    end else begin
      tbl.rd_data <= mem[tbl.rd_addr];
    end
  end
endmodule

// ===== logic/eodr_detect.sv
/*
  End-of-discharge detection, capacity relearn and temperature
  compensation of remaining capacity, updated once per measurement.
  Assumes all data inputs come from logic on mclk and change only
  around the meas_strobe pulse; tables are loaded before gauging.
*/
`timescale 1ns/1ps
module eodr_detect (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic meas_strobe,
  input wire logic [15:0] cell_mv,
  input wire logic [7:0] temp_code,
  input wire logic signed [7:0] temp_deg,
  input wire logic [7:0] rate_code,
  input wire logic [15:0] discharge_mah,
  input wire logic [15:0] charge_mah,
  input wire logic [7:0] error_inc,
  input wire logic fully_charged_event,
  input wire logic [6:0] clear_full_rsoc,
  input wire logic [63:0] temp_boundary_codes,
  input wire logic [63:0] rate_boundary_codes,
  input wire logic [63:0] residual_capacity_codes,
  input wire logic [7:0] eod_confirm_periods,
  input wire logic [7:0] relearn_rate_limit,
  input wire logic [15:0] cap_alarm_level,
  input wire logic [15:0] runtime_min,
  input wire logic [15:0] time_alarm_level,
  input wire logic tbl_wr_en,
  input wire logic [5:0] tbl_wr_addr,
  input wire logic [7:0] tbl_wr_data,
  output logic [15:0] eod_threshold_mv,
  output logic [15:0] battery_status,
  output logic alarm_warning,
  output logic [7:0] max_error,
  output logic [15:0] learned_full_charge,
  output logic [15:0] full_charge_capacity,
  output logic [15:0] remaining_capacity,
  output logic [6:0] rsoc
);
  logic [1:0] rst_q;
  logic rst_n;
  eodr_tbl_if tbl ();
  eodr_pkg::eodr_state_t state;
  logic [7:0] t_above, r_above;
  logic [2:0] col, row, col_cold;
  logic [7:0] res_cur, res_cold, tdiff, dres;
  logic [11:0] span_deg;
  logic [15:0] comp, res_cap, usable, relearn_val;
  logic [15:0] debt, next_debt, next_rm, used_since_full;
  logic [16:0] sub;
  logic [7:0] cnt;
  logic signed [7:0] last_deg;
  logic cooling, warming, below, eod_event, partial_charge;
  logic relearn_armed, fully_charged, discharge_end;
  logic low_charge, low_runtime;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // boundary compares, one per temperature band and one per rate band
  genvar gi;
  for (gi = 0; gi < eodr_pkg::NCOL; gi++) begin : g_bound
    assign t_above[gi] = temp_boundary_codes[8*gi +: 8] > temp_code;
    assign r_above[gi] = rate_boundary_codes[8*gi +: 8] > rate_code;
  end

  always_comb begin
    col = 3'(eodr_pkg::NCOL - 1);
    row = 3'(eodr_pkg::NROW - 1);
    for (int k = eodr_pkg::NCOL - 1; k >= 0; k--) begin
      if (t_above[k]) begin
        col = 3'(k);
      end
      if (r_above[k]) begin
        row = 3'(k);
      end
    end
  end

  // one row per rate band, one column per temperature band
  assign tbl.rd_addr = {row, col};
  assign tbl.wr_en = tbl_wr_en;
  assign tbl.wr_addr = tbl_wr_addr;
  assign tbl.wr_data = tbl_wr_data;

  eodr_tbl_mem u_tbl (
    .mclk(mclk),
    .rst_n(rst_n),
    .tbl(tbl)
  );

  // lookup runs every cycle, so the threshold tracks conditions
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eod_threshold_mv <= eodr_pkg::EOD_MV_BASE;
    end else begin
      eod_threshold_mv <= eodr_pkg::EOD_MV_BASE
        + 16'({8'h00, tbl.rd_data} * eodr_pkg::EOD_MV_STEP);
    end
  end

  // interpolation across the colder neighbour column
  assign col_cold = (col == 3'h0) ? 3'h0 : col - 3'h1;
  assign res_cur = residual_capacity_codes[8*col +: 8];
  assign res_cold = residual_capacity_codes[8*col_cold +: 8];
  assign dres = (res_cold > res_cur) ? res_cold - res_cur : 8'h00;
  assign tdiff = temp_boundary_codes[8*col +: 8]
    - temp_boundary_codes[8*col_cold +: 8];
  always_comb begin
    span_deg = ({4'h0, tdiff} * eodr_pkg::TCODE_NUM) / eodr_pkg::TCODE_DEN;
    if (span_deg == 12'h000) begin
      span_deg = 12'h001;
    end
  end
  // per-degree share of the residual step between the two columns
  assign comp = 16'(({8'h00, learned_full_charge} * {16'h0000, dres})
    / (32'(eodr_pkg::RESIDUAL_FULL) * {20'h00000, span_deg}));
  assign res_cap = 16'(({8'h00, learned_full_charge} * {16'h0000, res_cur})
    / {16'h0000, eodr_pkg::RESIDUAL_FULL});
  assign usable = learned_full_charge - res_cap;
  assign relearn_val = used_since_full + res_cap;

  assign cooling = meas_strobe && (temp_deg < last_deg);
  assign warming = meas_strobe && (temp_deg > last_deg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_deg <= 8'sh00;
    end else if (cooling) begin
      last_deg <= last_deg - 8'sh01;
    end else if (warming) begin
      last_deg <= last_deg + 8'sh01;
    end
  end

  // discharge first repays the debt left by warming steps
  always_comb begin
    next_debt = debt;
    sub = {1'b0, discharge_mah};
    if ({1'b0, debt} >= sub) begin
      next_debt = debt - discharge_mah;
      sub = 17'h00000;
    end else begin
      sub = sub - {1'b0, debt};
      next_debt = 16'h0000;
    end
    if (warming) begin
      next_debt = next_debt + comp;
    end
    if (cooling) begin
      sub = sub + {1'b0, comp};
    end
    next_rm = remaining_capacity + charge_mah;
    if (sub > {1'b0, next_rm}) begin
      next_rm = 16'h0000;
    end else begin
      next_rm = next_rm - sub[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remaining_capacity <= 16'h0000;
      debt <= 16'h0000;
    end else if (fully_charged_event) begin
      remaining_capacity <= usable;
      debt <= 16'h0000;
    end else if (meas_strobe) begin
      remaining_capacity <= next_rm;
      debt <= next_debt;
    end
  end

  // percentage of the capacity usable before save-to-disk
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsoc <= 7'h00;
    end else if (usable == 16'h0000 || remaining_capacity >= usable) begin
      rsoc <= 7'(eodr_pkg::RSOC_FULL);
    end else begin
      rsoc <= 7'(({16'h0000, remaining_capacity}
        * {16'h0000, eodr_pkg::RSOC_FULL}) / {16'h0000, usable});
    end
  end

  assign below = meas_strobe && (cell_mv < eod_threshold_mv);
  assign eod_event = below && (state != eodr_pkg::ST_ENDED)
    && (cnt + 8'h01 >= eod_confirm_periods);
  assign partial_charge = meas_strobe && (charge_mah != 16'h0000);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eodr_pkg::ST_WATCH;
      cnt <= 8'h00;
    end else begin
      case (state)
        eodr_pkg::ST_WATCH, eodr_pkg::ST_COUNT: begin
          if (eod_event) begin
            state <= eodr_pkg::ST_ENDED;
            cnt <= 8'h00;
          end else if (below) begin
            state <= eodr_pkg::ST_COUNT;
            cnt <= cnt + 8'h01;
          end else if (meas_strobe) begin
            // one good reading restarts the confirmation
            state <= eodr_pkg::ST_WATCH;
            cnt <= 8'h00;
          end
        end
        eodr_pkg::ST_ENDED: begin
          if (partial_charge) begin
            state <= eodr_pkg::ST_WATCH;
          end
        end
        default: begin
          state <= eodr_pkg::ST_WATCH;
          cnt <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      discharge_end <= 1'b0;
      alarm_warning <= 1'b0;
    end else begin
      alarm_warning <= eod_event;
      if (eod_event) begin
        discharge_end <= 1'b1;
      end else if (partial_charge) begin
        discharge_end <= 1'b0;
      end
    end
  end

  // early warnings, independent of the confirmed end point
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      low_charge <= 1'b0;
      low_runtime <= 1'b0;
    end else begin
      low_charge <= remaining_capacity < cap_alarm_level;
      low_runtime <= runtime_min < time_alarm_level;
    end
  end

  // full flag: set wins over the percentage-based clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fully_charged <= 1'b0;
      relearn_armed <= 1'b0;
    end else begin
      if (fully_charged_event) begin
        fully_charged <= 1'b1;
      end else if (rsoc < clear_full_rsoc) begin
        fully_charged <= 1'b0;
      end
      if (fully_charged_event) begin
        relearn_armed <= 1'b1;
      end else if (partial_charge || eod_event) begin
        relearn_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      used_since_full <= 16'h0000;
    end else if (fully_charged_event) begin
      used_since_full <= 16'h0000;
    end else if (meas_strobe) begin
      used_since_full <= used_since_full + discharge_mah;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      learned_full_charge <= eodr_pkg::LFC_RESET;
      full_charge_capacity <= eodr_pkg::LFC_RESET;
    end else if (eod_event && relearn_armed && !partial_charge
                 && rate_code <= relearn_rate_limit) begin
      learned_full_charge <= relearn_val;
      full_charge_capacity <= relearn_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      max_error <= 8'h00;
    end else if (eod_event) begin
      max_error <= 8'h00;
    end else if (meas_strobe) begin
      if ({1'b0, max_error} + {1'b0, error_inc}
          >= {1'b0, eodr_pkg::MAX_ERROR_CAP}) begin
        max_error <= eodr_pkg::MAX_ERROR_CAP;
      end else begin
        max_error <= max_error + error_inc;
      end
    end
  end

  always_comb begin
    battery_status = 16'h0000;
    battery_status[eodr_pkg::BIT_DISCHARGE_END] = discharge_end;
    battery_status[eodr_pkg::BIT_LOW_CHARGE] = low_charge;
    battery_status[eodr_pkg::BIT_LOW_RUNTIME] = low_runtime;
    battery_status[eodr_pkg::BIT_FULLY_CHARGED] = fully_charged;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_thr_decode;
    $stable(tbl.rd_data) |-> eod_threshold_mv == eodr_pkg::EOD_MV_BASE
      + 16'({8'h00, $past(tbl.rd_data)} * eodr_pkg::EOD_MV_STEP);
  endproperty
  a_thr_decode: assert property (p_thr_decode)
    else $error("threshold decode wrong");
  property p_eod_cause;
    eod_event |-> cell_mv < eod_threshold_mv
      && cnt + 8'h01 >= eod_confirm_periods
      && (eod_confirm_periods <= 8'h01 || state == eodr_pkg::ST_COUNT);
  endproperty
  a_eod_cause: assert property (p_eod_cause)
    else $error("end of discharge without confirmation");
  property p_eod_alarm;
    eod_event |=> alarm_warning && battery_status[11] ##1 !alarm_warning;
  endproperty
  a_eod_alarm: assert property (p_eod_alarm)
    else $error("alarm not raised once");
  property p_err_clear;
    eod_event |=> max_error == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error not cleared");
  property p_relearn;
    eod_event && relearn_armed && !partial_charge
      && rate_code <= relearn_rate_limit
      |=> learned_full_charge == $past(relearn_val)
      && full_charge_capacity == learned_full_charge;
  endproperty
  a_relearn: assert property (p_relearn)
    else $error("relearn value wrong");
  property p_rate_skip;
    eod_event && rate_code > relearn_rate_limit |=> $stable(learned_full_charge);
  endproperty
  a_rate_skip: assert property (p_rate_skip)
    else $error("relearn at high rate");
  property p_cancel;
    partial_charge && !fully_charged_event |=> !relearn_armed;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("partial charge kept relearn");
  property p_full_bit;
    fully_charged_event |=> battery_status[5] && relearn_armed;
  endproperty
  a_full_bit: assert property (p_full_bit)
    else $error("full charge not flagged");
  property p_freeze;
    meas_strobe && !fully_charged_event && !cooling && charge_mah == 16'h0000
      && debt >= discharge_mah |=> $stable(remaining_capacity);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("capacity moved while frozen");
  property p_col_sel;
    (t_above[col] || col == 3'h7)
      && (col == 3'h0 || !t_above[col - 3'h1]);
  endproperty
  a_col_sel: assert property (p_col_sel)
    else $error("column selection wrong");
  c_eod: cover property (eod_event);
  c_relearn: cover property (eod_event && relearn_armed);
  c_cool: cover property (cooling && comp != 16'h0000);
  c_warm_freeze: cover property (warming ##[1:20] debt != 16'h0000);
endmodule

// ===== sim/eodr_host_model.sv
/*
  Host and charger stand-in: listens for alarm broadcasts and keeps
  the status word that came with the latest one.
  Assumes alarm_warning is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
module eodr_host_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic alarm_warning,
  input wire logic [15:0] battery_status,
  output logic [7:0] alarm_count,
  output logic [15:0] alarm_status
);
  // a pulse longer than one cycle would count once per cycle high, on purpose
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_count <= 8'h00;
      alarm_status <= 16'h0000;
    end else if (alarm_warning) begin
      alarm_count <= alarm_count + 8'h01;
      alarm_status <= battery_status;
    end
  end
endmodule

// ===== sim/eodr_detect_bench.sv
/*
  Self-checking bench of the end-of-discharge detector.
  Assumes the detector's documented timing; inputs change on negedge.
*/
`timescale 1ns/1ps
module eodr_detect_bench;
  logic mclk, arst_n, meas_strobe, fully_charged_event, tbl_wr_en;
  logic [15:0] cell_mv, discharge_mah, charge_mah, rc;
  logic [7:0] temp_code, rate_code, error_inc, tbl_wr_data;
  logic signed [7:0] temp_deg;
  logic [5:0] tbl_wr_addr;
  logic [7:0] confirm, rate_lim, alarm_count;
  logic [15:0] cap_lvl, run_min, time_lvl;
  logic [6:0] clr_rsoc;
  logic [63:0] temp_bounds, rate_bounds, res_codes;
  logic [15:0] eod_threshold_mv, battery_status, alarm_status;
  logic [15:0] learned_full_charge, full_charge_capacity;
  logic [15:0] remaining_capacity;
  logic alarm_warning;
  logic [7:0] max_error;
  logic [6:0] rsoc;
  int mismatches, checks;
  logic [7:0] tcs [5] = '{8'h04, 8'h05, 8'h95, 8'hff, 8'h28};
  logic [7:0] rcs [5] = '{8'h00, 8'h13, 8'h6c, 8'hff, 8'h00};
  logic [15:0] ads [5] = '{16'h0000, 16'h0009, 16'h0036, 16'h003f,
                           16'h0003};
  localparam logic [15:0] LOW = 16'h07d0;
  localparam logic [15:0] HIGH = 16'h0fa0;

  eodr_detect DUT (
    .mclk(mclk), .arst_n(arst_n), .meas_strobe(meas_strobe),
    .cell_mv(cell_mv), .temp_code(temp_code), .temp_deg(temp_deg),
    .rate_code(rate_code), .discharge_mah(discharge_mah),
    .charge_mah(charge_mah), .error_inc(error_inc),
    .fully_charged_event(fully_charged_event),
    .clear_full_rsoc(clr_rsoc), .temp_boundary_codes(temp_bounds),
    .rate_boundary_codes(rate_bounds),
    .residual_capacity_codes(res_codes),
    .eod_confirm_periods(confirm), .relearn_rate_limit(rate_lim),
    .cap_alarm_level(cap_lvl), .runtime_min(run_min),
    .time_alarm_level(time_lvl), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
    .eod_threshold_mv(eod_threshold_mv),
    .battery_status(battery_status), .alarm_warning(alarm_warning),
    .max_error(max_error), .learned_full_charge(learned_full_charge),
    .full_charge_capacity(full_charge_capacity),
    .remaining_capacity(remaining_capacity), .rsoc(rsoc)
  );

  eodr_host_model host (
    .mclk(mclk), .arst_n(arst_n), .alarm_warning(alarm_warning),
    .battery_status(battery_status), .alarm_count(alarm_count),
    .alarm_status(alarm_status)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // gap of three cycles keeps the threshold pipeline settled
  task automatic strobe(input logic [15:0] mv, input logic [15:0] dis,
                        input logic [15:0] chg);
    cell_mv = mv;
    discharge_mah = dis;
    charge_mah = chg;
    meas_strobe = 1'b1;
    tick(1);
    meas_strobe = 1'b0;
    tick(3);
  endtask

  task automatic full_charge;
    fully_charged_event = 1'b1;
    tick(1);
    fully_charged_event = 1'b0;
    tick(2);
  endtask

  task automatic reach_end;
    repeat (3) strobe(LOW, 16'h0000, 16'h0000);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    mismatches++;
    print_verdict();
  end

  initial begin
    arst_n = 1'b0;
    {meas_strobe, fully_charged_event, tbl_wr_en} = 3'b000;
    {cell_mv, discharge_mah, charge_mah} = 48'h0;
    {temp_code, rate_code, tbl_wr_data, tbl_wr_addr} = 30'h0;
    temp_deg = 8'sh00;
    error_inc = 8'h03;
    confirm = 8'h03;
    rate_lim = 8'h64;
    cap_lvl = 16'h0000;
    run_min = 16'h0014;
    time_lvl = 16'h000a;
    clr_rsoc = 7'h00;
    temp_bounds = 64'hc896_7150_3223_1405;
    rate_bounds = 64'h786d_5a4d_4030_2013;
    res_codes = 64'h0000_0000_1428_0000;
    tick(5);
    check("reset threshold", eod_threshold_mv, 16'h0a8c);
    check("reset capacity", learned_full_charge, 16'h0fa0);
    arst_n = 1'b1;
    tick(3);
    for (int i = 0; i < 64; i++) begin
      tbl_wr_en = 1'b1;
      tbl_wr_addr = i[5:0];
      tbl_wr_data = 8'(i + 1);
      tick(1);
    end
    tbl_wr_en = 1'b0;
    // strict boundary compare and last-entry fallback at the edges
    for (int i = 0; i < 5; i++) begin
      temp_code = tcs[i];
      rate_code = rcs[i];
      tick(4);
      check("threshold", eod_threshold_mv, eodr_pkg::EOD_MV_BASE +
            eodr_pkg::EOD_MV_STEP * (ads[i] + 16'h0001));
    end
    // a reading above threshold restarts the confirmation count
    repeat (2) strobe(LOW, 16'h0000, 16'h0000);
    strobe(HIGH, 16'h0000, 16'h0000);
    repeat (2) strobe(LOW, 16'h0000, 16'h0000);
    check("early end", battery_status & 16'h0800, 16'h0000);
    strobe(LOW, 16'h0000, 16'h0000);
    check("alarms", {8'h00, alarm_count}, 16'h0001);
    check("alarm word", alarm_status & 16'h0800, 16'h0800);
    check("end bit", battery_status & 16'h0800, 16'h0800);
    check("pulse", {15'h0, alarm_warning}, 16'h0000);
    check("error cleared", {8'h00, max_error}, 16'h0000);
    check("unarmed", learned_full_charge, 16'h0fa0);
    strobe(LOW, 16'h0000, 16'h0000);
    check("ended", {8'h00, alarm_count}, 16'h0001);
    strobe(HIGH, 16'h0000, 16'h000a);
    check("end bit off", battery_status & 16'h0800, 16'h0000);
    check("error 1", {8'h00, max_error}, 16'h0006);
    strobe(HIGH, 16'h0000, 16'h0000);
    check("error 2", {8'h00, max_error}, 16'h0009);
    // column with no residual: relearn equals capacity drawn
    temp_code = 8'hff;
    tick(4);
    full_charge();
    check("full bit", battery_status & 16'h0020, 16'h0020);
    strobe(HIGH, 16'h02bc, 16'h0000);
    strobe(HIGH, 16'h0320, 16'h0000);
    reach_end();
    check("relearned", learned_full_charge, 16'h05dc);
    check("fcc", full_charge_capacity, 16'h05dc);
    check("alarms", {8'h00, alarm_count}, 16'h0002);
    strobe(HIGH, 16'h0000, 16'h000a);
    full_charge();
    rate_code = 8'hc8;
    strobe(HIGH, 16'h0384, 16'h0000);
    reach_end();
    check("fast rate", learned_full_charge, 16'h05dc);
    check("error cleared", {8'h00, max_error}, 16'h0000);
    rate_code = 8'h00;
    strobe(HIGH, 16'h0000, 16'h000a);
    full_charge();
    strobe(HIGH, 16'h012c, 16'h0000);
    strobe(HIGH, 16'h0000, 16'h0005);
    reach_end();
    check("partial", learned_full_charge, 16'h05dc);
    // column with a colder neighbour so compensation is nonzero
    strobe(HIGH, 16'h0000, 16'h000a);
    temp_code = 8'h28;
    tick(4);
    full_charge();
    check("full rsoc", {9'h0, rsoc}, eodr_pkg::RSOC_FULL);
    // 1500 mAh less a 20/255 residual share
    check("usable", remaining_capacity, 16'h0567);
    rc = remaining_capacity;
    temp_deg = -8'sh01;
    strobe(HIGH, 16'h0000, 16'h0000);
    // 1500 * 20 / (255 * 6 degrees) per degree
    check("cooler", remaining_capacity, rc - 16'h0013);
    rc = remaining_capacity;
    temp_deg = 8'sh00;
    strobe(HIGH, 16'h0000, 16'h0000);
    check("warmer", remaining_capacity, rc);
    strobe(HIGH, 16'h000a, 16'h0000);
    check("frozen", remaining_capacity, rc);
    strobe(HIGH, 16'hffff, 16'h0000);
    check("empty rsoc", {9'h0, rsoc}, 16'h0000);
    check("no early", battery_status & 16'h0300, 16'h0000);
    cap_lvl = 16'h0001;
    run_min = 16'h0005;
    clr_rsoc = 7'h0a;
    tick(2);
    check("early", battery_status & 16'h0320, 16'h0300);
    print_verdict();
  end
endmodule
